// ---- hdl/midt_defs.svh ----
// Timing shapes, opcodes and counts for the instruction decode and timing block.
`ifndef MIDT_DEFS_SVH
`define MIDT_DEFS_SVH

// Shapes are {byte length[5:4], cycle count[3:0]}.
`define MIDT_T11 6'h11
`define MIDT_T12 6'h12
`define MIDT_T13 6'h13
`define MIDT_T14 6'h14
`define MIDT_T15 6'h15
`define MIDT_T22 6'h22
`define MIDT_T23 6'h23
`define MIDT_T24 6'h24
`define MIDT_T25 6'h25
`define MIDT_T26 6'h26
`define MIDT_T33 6'h33
`define MIDT_T34 6'h34
`define MIDT_T36 6'h36

// Field positions inside a shape.
`define MIDT_LEN_MSB 5
`define MIDT_LEN_LSB 4
`define MIDT_CYC_MSB 3

// External data moves: base cycle count before stretch is added.
`define MIDT_XRD_BASE 4'h3
`define MIDT_XWR_BASE 4'h4

// Opcodes watched outside the decode table.
`define MIDT_OP_TRAP 8'ha5
`define MIDT_OP_PTR_INC 8'ha3
`define MIDT_OP_DIR_IMM_OR 8'h43
`define MIDT_OP_XRD_PTR 8'he0
`define MIDT_OP_REG_FROM_DIR 8'ha8
`define MIDT_OP_SWAP 8'hc4

// Program counter reset value and cycle counter load value.
`define MIDT_PC_RESET 16'h0000
`define MIDT_CYC_ONE 4'h1

`endif

// ---- hdl/midt_pkg.sv ----
// Types shared by the instruction decode and timing block.
`default_nettype none

package midt_pkg;

  // Sequencer states.
  typedef enum logic [1:0] {
    MIDT_ST_IDLE = 2'b00,
    MIDT_ST_OPCODE = 2'b01,
    MIDT_ST_EXEC = 2'b10
  } midt_state_e;

  // Everything the decoder knows about one opcode.
  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cyc;
    logic wreg;
    logic [2:0] reg_num;
    logic [2:0] page;
    logic page_jump;
    logic trap;
    logic xrd;
    logic xwr;
  } midt_dec_s;

endpackage

`default_nettype wire

// ---- hdl/midt_core.sv ----
// Instruction decode and cycle sequencer for the 8-bit controller core.
`default_nettype none
`include "midt_defs.svh"

module midt_core (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Program memory fetch port; data answers the address in the same cycle.
  output logic [15:0] code_addr_o,
  output logic code_rd_o,
  input wire logic [7:0] code_data_i,
  // Stretch setting for external data moves.
  input wire logic [2:0] stretch_i,
  // Decoded instruction handed to the execute side.
  output logic [7:0] opcode_o,
  output midt_pkg::midt_dec_s instr_o,
  output logic [15:0] operand_o,
  output logic [3:0] cycle_o,
  output logic instr_start_o,
  output logic instr_last_o,
  // Pulse to the on-chip debug logic.
  output logic debug_trap_o
);

  // ****************************************************************
  // Opcode decode table
  // ****************************************************************

  // Maps one opcode to its length, cycle count and operand fields.
  function automatic midt_pkg::midt_dec_s dec_op(input logic [7:0] op,
                                                 input logic [2:0] str);
    midt_pkg::midt_dec_s d;
    logic [5:0] t;
    d = '0;
    t = `MIDT_T11;
    casez (op)
      8'h00: t = `MIDT_T11;
      8'b???0_0001: t = `MIDT_T23;
      8'b???1_0001: t = `MIDT_T26;
      8'h02: t = `MIDT_T34;
      8'h12: t = `MIDT_T36;
      8'b00??_0011: t = `MIDT_T11;
      8'b000?_0100: t = `MIDT_T11;
      8'b000?_0101: t = `MIDT_T23;
      8'b000?_011?: t = `MIDT_T13;
      8'b0000_1???: t = `MIDT_T12;
      8'b0001_1???: t = `MIDT_T11;
      8'b00??_0000: t = `MIDT_T34;
      8'b001?_0010: t = `MIDT_T14;
      8'b01??_0000: t = `MIDT_T23;
      8'h72: t = `MIDT_T22;
      8'h73: t = `MIDT_T12;
      8'b01??_0010: t = `MIDT_T23;
      8'b01??_0011: t = `MIDT_T34;
      8'h75: t = `MIDT_T33;
      8'b0111_011?: t = `MIDT_T23;
      8'b0111_1???: t = `MIDT_T22;
      8'h80: t = `MIDT_T23;
      8'h82: t = `MIDT_T22;
      8'b100?_0011: t = `MIDT_T13;
      8'h84: t = `MIDT_T15;
      8'h85: t = `MIDT_T34;
      8'b1000_011?: t = `MIDT_T24;
      8'b1000_1???: t = `MIDT_T23;
      8'h90: t = `MIDT_T33;
      8'h92: t = `MIDT_T23;
      8'b101?_0000: t = `MIDT_T22;
      8'ha2: t = `MIDT_T22;
      8'ha3: t = `MIDT_T13;
      8'ha4: t = `MIDT_T15;
      `MIDT_OP_TRAP:
      begin
        t = `MIDT_T11;
        d.trap = 1'b1;
      end
      8'b1010_011?: t = `MIDT_T25;
      8'b1010_1???: t = `MIDT_T24;
      8'hb2: t = `MIDT_T23;
      8'b1011_01??: t = `MIDT_T34;
      8'b1011_1???: t = `MIDT_T34;
      8'hc0: t = `MIDT_T24;
      8'hd0: t = `MIDT_T23;
      8'b110?_0010: t = `MIDT_T23;
      8'b1?0?_0011: t = `MIDT_T11;
      8'b110?_0100: t = `MIDT_T11;
      8'hc5: t = `MIDT_T23;
      8'b1100_011?: t = `MIDT_T13;
      8'b1100_1???: t = `MIDT_T12;
      8'hd5: t = `MIDT_T34;
      8'b1101_011?: t = `MIDT_T13;
      8'b1101_1???: t = `MIDT_T23;
      8'b1110_00?0, 8'he3:
      begin
        t = `MIDT_T11;
        d.xrd = 1'b1;
      end
      8'b1111_00?0, 8'hf3:
      begin
        t = `MIDT_T11;
        d.xwr = 1'b1;
      end
      8'b111?_0100: t = `MIDT_T11;
      8'hf5: t = `MIDT_T23;
      8'b1111_011?: t = `MIDT_T13;
      8'b1111_1???: t = `MIDT_T12;
      // Accumulator-operand rows: immediate, direct, indirect, register.
      8'b????_010?: t = `MIDT_T22;
      8'b????_011?: t = `MIDT_T12;
      8'b????_1???: t = `MIDT_T11;
      default: t = `MIDT_T11;
    endcase
    d.len = t[`MIDT_LEN_MSB:`MIDT_LEN_LSB];
    d.cyc = t[`MIDT_CYC_MSB:0];
    // Stretch lengthens only the external data moves.
    if (d.xrd)
      d.cyc = `MIDT_XRD_BASE + {1'b0, str};
    if (d.xwr)
      d.cyc = `MIDT_XWR_BASE + {1'b0, str};
    // Low opcode bits name the register; indirect forms use bit 0 only.
    d.wreg = op[3];
    d.reg_num = op[3] ? op[2:0] : {2'b00, op[0]};
    d.page_jump = (op[3:0] == 4'h1);
    d.page = op[7:5];
    return d;
  endfunction

  // ****************************************************************
  // Sequencer state
  // ****************************************************************

  midt_pkg::midt_state_e st_r;
  midt_pkg::midt_state_e st_nxt;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [1:0] fet_r;
  logic [1:0] fet_nxt;
  midt_pkg::midt_dec_s dec_r;
  logic [7:0] opc_r;
  logic [15:0] opnd_r;
  logic start_r;
  logic trap_r;

  // Decode and cycle-position terms.
  midt_pkg::midt_dec_s dec_w;
  wire logic in_op_w;
  wire logic in_exec_w;
  wire logic last_w;
  wire logic fetch_w;
  wire logic op_single_w;

  assign dec_w = dec_op(code_data_i, stretch_i);
  assign in_op_w = (st_r == midt_pkg::MIDT_ST_OPCODE);
  assign in_exec_w = (st_r == midt_pkg::MIDT_ST_EXEC);
  assign op_single_w = (dec_w.cyc == `MIDT_CYC_ONE);
  // The opcode fetch cycle counts as cycle zero; the counter is loaded with one for the cycle after it.
  assign last_w = (in_op_w && op_single_w) ||
                  (in_exec_w && (cnt_r == dec_r.cyc - `MIDT_CYC_ONE));
  // Operand bytes are fetched right behind the opcode; the fetch of the
  // next opcode follows the last cycle so the execute side works on the
  // held instruction while memory serves the next one.
  assign fetch_w = in_op_w || (in_exec_w && (fet_r < dec_r.len));

  // Next-state logic for the sequencer.
  always_comb
  begin
    st_nxt = st_r;
    pc_nxt = fetch_w ? pc_r + 16'h0001 : pc_r;
    cnt_nxt = cnt_r;
    fet_nxt = fet_r;
    case (st_r)
      midt_pkg::MIDT_ST_IDLE:
      begin
        st_nxt = midt_pkg::MIDT_ST_OPCODE;
      end
      midt_pkg::MIDT_ST_OPCODE:
      begin
        cnt_nxt = `MIDT_CYC_ONE;
        fet_nxt = 2'd1;
        st_nxt = op_single_w ? midt_pkg::MIDT_ST_OPCODE : midt_pkg::MIDT_ST_EXEC;
      end
      midt_pkg::MIDT_ST_EXEC:
      begin
        cnt_nxt = cnt_r + 4'h1;
        if (fetch_w)
          fet_nxt = fet_r + 2'd1;
        if (last_w)
          st_nxt = midt_pkg::MIDT_ST_OPCODE;
      end
      default:
      begin
        st_nxt = midt_pkg::MIDT_ST_IDLE;
      end
    endcase
  end

  // State, program counter and counters.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_r <= midt_pkg::MIDT_ST_IDLE;
      pc_r <= `MIDT_PC_RESET;
      cnt_r <= 4'h0;
      fet_r <= 2'd0;
    end
    else
    begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      cnt_r <= cnt_nxt;
      fet_r <= fet_nxt;
    end
  end

  // ****************************************************************
  // Instruction capture
  // ****************************************************************

  // Opcode and its decode are held for the whole instruction.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      opc_r <= 8'h00;
      dec_r <= '0;
      start_r <= 1'b0;
      trap_r <= 1'b0;
    end
    else
    begin
      start_r <= in_op_w;
      trap_r <= in_op_w && dec_w.trap;
      if (in_op_w)
      begin
        opc_r <= code_data_i;
        dec_r <= dec_w;
      end
    end
  end

  // Second byte lands low and third byte high, so a sixteen-bit constant
  // reads back least significant byte first as it sits in code memory.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      opnd_r <= 16'h0000;
    else if (in_op_w)
      opnd_r <= 16'h0000;
    else if (in_exec_w && fetch_w && fet_r == 2'd1)
      opnd_r[7:0] <= code_data_i;
    else if (in_exec_w && fetch_w && fet_r == 2'd2)
      opnd_r[15:8] <= code_data_i;
  end

  // Outputs.
  assign code_addr_o = pc_r;
  assign code_rd_o = fetch_w;
  assign opcode_o = opc_r;
  assign instr_o = dec_r;
  assign operand_o = opnd_r;
  assign cycle_o = cnt_r;
  assign instr_start_o = start_r;
  assign instr_last_o = last_w;
  assign debug_trap_o = trap_r;

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Opcode taken in the current cycle.
  wire logic [7:0] op_now_w;
  assign op_now_w = in_op_w ? code_data_i : 8'h00;
  // Clocks since the last opcode cycle, kept apart from cnt_r so the check does not lean on it.
  logic [3:0] span_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      span_r <= 4'h0;
    else if (in_op_w)
      span_r <= 4'h1;
    else if (span_r != 4'h0)
      span_r <= span_r + 4'h1;
  end

  sequence s_exec2;
    st_r == midt_pkg::MIDT_ST_EXEC [*2] ##1 st_r == midt_pkg::MIDT_ST_OPCODE;
  endsequence
  sequence s_exec3;
    st_r == midt_pkg::MIDT_ST_EXEC [*3] ##1 st_r == midt_pkg::MIDT_ST_OPCODE;
  endsequence

  a_ptr_inc_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    in_op_w && op_now_w == `MIDT_OP_PTR_INC |=> s_exec2)
    else $error("pointer increment not three cycles");

  a_alu_reg_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    in_op_w && op_now_w[7:4] inside {4'h4, 4'h5, 4'h6} && op_now_w[3]
    |=> in_op_w && pc_r == $past(pc_r) + 16'h0001)
    else $error("register logic op not one cycle");

  a_dir_imm_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    in_op_w && op_now_w == `MIDT_OP_DIR_IMM_OR
    |=> s_exec3 ##0 pc_r == $past(pc_r, 4) + 16'h0003)
    else $error("immediate to direct logic op not 3 bytes 4 cycles");

  a_swap_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    in_op_w && op_now_w == `MIDT_OP_SWAP |-> instr_last_o ##1 in_op_w)
    else $error("nibble swap not one cycle");

  a_reg_dir_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    in_op_w && op_now_w == `MIDT_OP_REG_FROM_DIR |=> s_exec3)
    else $error("direct to register not four cycles");

  a_xrd_stretch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    in_op_w && op_now_w == `MIDT_OP_XRD_PTR
    |=> instr_o.cyc == `MIDT_XRD_BASE + {1'b0, $past(stretch_i)} && instr_o.len == 2'd1)
    else $error("external read cycle count wrong");

  a_trap_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    in_op_w && op_now_w == `MIDT_OP_TRAP
    |=> debug_trap_o ##1 debug_trap_o == (opcode_o == `MIDT_OP_TRAP))
    else $error("trap opcode did not pulse debug logic");

  a_last_fetch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    instr_last_o |=> in_op_w && code_rd_o)
    else $error("next opcode not fetched after last cycle");

  a_reg_field: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    in_op_w && op_now_w[3] |=> instr_o.reg_num == $past(code_data_i[2:0]) && instr_o.wreg)
    else $error("work register number not from low opcode bits");

  a_cycle_count: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    in_op_w && span_r != 4'h0 |-> span_r == instr_o.cyc)
    else $error("instruction ended off its cycle count");

endmodule

`default_nettype wire

// ---- tb/midt_code_mem.sv ----
// Program memory model that answers the core's fetch port.
`default_nettype none

module midt_code_mem (
  // Clock.
  input wire logic clk_sys_i,
  // Fetch port.
  input wire logic [15:0] code_addr_i,
  input wire logic code_rd_i,
  output logic [7:0] code_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************
  // Storage and read path
  // ********************************

  // Loaded by the bench before each program; only the low 256 bytes are modelled.
  logic [7:0] mem_r [256];
  logic [7:0] last_r = 8'h00;

  // Zero wait states, so the byte appears in the cycle of the address.
  // Outside a fetch the bus shows the inverse of the last byte, so a core that
  // samples without its strobe picks up garbage instead of a lucky match.
  assign code_data_o = code_rd_i ? mem_r[code_addr_i[7:0]] : ~last_r;

  // Remember the last byte handed over.
  always_ff @(posedge clk_sys_i)
  begin
    if (code_rd_i)
      last_r <= code_data_o;
  end

endmodule

`default_nettype wire

// ---- tb/midt_core_test.sv ----
// Self-checking bench for the instruction decode and timing core.
`default_nettype none

module midt_core_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************
  // Signals, design and memory
  // ********************************

  localparam int WATCH_NS = 50000;
  logic clk_sys_i;
  logic rst_i;
  logic [2:0] stretch_i;
  logic [15:0] code_addr_o;
  logic code_rd_o;
  logic [7:0] code_data_i;
  logic [7:0] opcode_o;
  midt_pkg::midt_dec_s instr_w;
  logic [15:0] operand_o;
  logic [3:0] cycle_o;
  logic instr_start_o;
  logic instr_last_o;
  logic debug_trap_o;
  int fail_count = 0;
  int n_compared = 0;

  midt_core i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .code_addr_o(code_addr_o), .code_rd_o(code_rd_o),
    .code_data_i(code_data_i), .stretch_i(stretch_i), .opcode_o(opcode_o),
    .instr_o(instr_w), .operand_o(operand_o), .cycle_o(cycle_o),
    .instr_start_o(instr_start_o), .instr_last_o(instr_last_o), .debug_trap_o(debug_trap_o)
  );

  midt_code_mem i_mem (
    .clk_sys_i(clk_sys_i), .code_addr_i(code_addr_o), .code_rd_i(code_rd_o),
    .code_data_o(code_data_i)
  );

  // Clock at 100 MHz.
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ********************************
  // Shared tasks
  // ********************************

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Each entry is {opcode, byte length, cycle count}. The program is loaded from
  // address zero, the core reset, and every instruction timed start to start.
  task automatic run_seq(input logic [15:0] prog[$]);
    logic [15:0] addr_x [33];
    logic [15:0] opnd_x [33];
    logic [15:0] a;
    logic [15:0] gap;
    logic [15:0] ent;
    logic [7:0] v;
    logic last_q1;
    logic last_q2;
    logic [15:0] opnd_q1;
    int guard;
    int k;
    a = 16'h0000;
    for (int i = 0; i < 256; i++)
      i_mem.mem_r[i] = 8'h00;
    foreach (prog[j])
    begin
      addr_x[j] = a;
      opnd_x[j] = 16'h0000;
      i_mem.mem_r[a[7:0]] = prog[j][15:8];
      for (int b = 1; b < int'(prog[j][5:4]); b++)
      begin
        v = (a[7:0] + 8'(b)) ^ 8'ha5;
        i_mem.mem_r[a[7:0] + 8'(b)] = v;
        opnd_x[j][8 * (b - 1) +: 8] = v;
      end
      a = a + {14'h0000, prog[j][5:4]};
    end
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    check("fetch strobe in reset", {15'h0000, code_rd_o}, 16'h0000);
    check("fetch address in reset", code_addr_o, 16'h0000);
    rst_i = 1'b0;
    gap = 16'h0000;
    last_q1 = 1'b0;
    last_q2 = 1'b0;
    opnd_q1 = 16'h0000;
    guard = 0;
    k = 0;
    while (k <= prog.size())
    begin
      @(negedge clk_sys_i);
      gap = gap + 16'h0001;
      guard++;
      if (guard > 40)
      begin
        fail_count++;
        wrap_up();
      end
      if (instr_start_o === 1'b1)
      begin
        if (k > 0)
        begin
          ent = prog[k - 1];
          check("cycles", gap, {12'h000, ent[3:0]});
          check("last flag", {15'h0000, last_q2}, 16'h0001);
          check("operand", opnd_q1, opnd_x[k - 1]);
        end
        if (k < prog.size())
        begin
          ent = prog[k];
          check("opcode", {8'h00, opcode_o}, {8'h00, ent[15:8]});
          check("length", {14'h0000, instr_w.len}, {14'h0000, ent[5:4]});
          check("cycle count", {12'h000, instr_w.cyc}, {12'h000, ent[3:0]});
          check("fetch address", code_addr_o, addr_x[k] + 16'h0001);
          check("cycle index", {12'h000, cycle_o}, 16'h0001);
          check("fetch strobe", {15'h0000, code_rd_o},
                {15'h0000, ent[5:4] > 2'd1 || ent[3:0] == 4'h1});
          check("external move", {14'h0000, instr_w.xrd, instr_w.xwr},
                {14'h0000, ent[15:12] == 4'he && ent[11:8] inside {4'h0, 4'h2, 4'h3},
                 ent[15:12] == 4'hf && ent[11:8] inside {4'h0, 4'h2, 4'h3}});
          check("trap", {15'h0000, debug_trap_o}, {15'h0000, ent[15:8] == 8'ha5});
          if (ent[11])
            check("register", {13'h0000, instr_w.reg_num}, {13'h0000, ent[10:8]});
          if (ent[12:8] == 5'h01)
            check("page", {13'h0000, instr_w.page}, {13'h0000, ent[15:13]});
        end
        gap = 16'h0000;
        guard = 0;
        k++;
      end
      last_q2 = last_q1;
      last_q1 = instr_last_o;
      opnd_q1 = operand_o;
    end
  endtask

  // ********************************
  // Scenarios
  // ********************************

  // Logic operations in every source form, back to back.
  task automatic logic_ops();
    run_seq('{16'h5811, 16'h5522, 16'h4612, 16'h6422, 16'h4334, 16'h5334, 16'h6334,
              16'h5223, 16'h4223, 16'h6223, 16'h6f11, 16'h4c11});
  endtask

  // Single-cycle accumulator operations followed by the pointer increment.
  task automatic accu_ops();
    run_seq('{16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hc411,
              16'ha313, 16'ha313});
  endtask

  // Moves, pointer load and code byte reads.
  task automatic move_ops();
    run_seq('{16'hf912, 16'ha824, 16'haf24, 16'h8534, 16'h7533, 16'ha625, 16'hf613,
              16'h9033, 16'h8313, 16'h9313});
  endtask

  // External RAM moves at the shortest and the longest stretch setting.
  task automatic ext_ops();
    logic [3:0] xr;
    logic [3:0] xw;
    for (int s = 0; s < 8; s += 7)
    begin
      stretch_i = 3'(s);
      xr = 4'h3 + 4'(s);
      xw = 4'h4 + 4'(s);
      run_seq('{{8'he0, 4'h1, xr}, {8'he2, 4'h1, xr}, {8'he3, 4'h1, xr},
                {8'hf0, 4'h1, xw}, {8'hf2, 4'h1, xw}, {8'hf3, 4'h1, xw}});
    end
    stretch_i = 3'h0;
  endtask

  // Stack, exchanges and bit operations.
  task automatic bit_ops();
    run_seq('{16'hc024, 16'hd023, 16'hd613, 16'hd713, 16'hca12, 16'hc523, 16'hc311,
              16'hd311, 16'hb311, 16'hc223, 16'hd223, 16'hb223, 16'h8222, 16'hb022,
              16'h7222, 16'ha022, 16'ha222, 16'h9223});
    // The same list covers the carry and direct-bit forms.
  endtask

  // Branches, page jump and the debug trap in mid-program.
  task automatic branch_ops();
    run_seq('{16'h7312, 16'h8023, 16'h6023, 16'h7023, 16'h4023, 16'h5023, 16'h2034,
              16'h3034, 16'h1034, 16'ha511, 16'hb534, 16'hb434, 16'hb634, 16'hbb34,
              16'hdd23, 16'hd534, 16'h2123});
    // Register and direct countdown loops are in the list too.
  endtask

  // ********************************
  // Main sequence and watchdog
  // ********************************

  // Inputs change on the falling edge only.
  initial
  begin
    rst_i = 1'b1;
    stretch_i = 3'h0;
    @(negedge clk_sys_i);
    logic_ops();
    accu_ops();
    move_ops();
    ext_ops();
    bit_ops();
    branch_ops();
    wrap_up();
  end

  // The whole run needs well under a thousand cycles.
  initial
  begin
    #(WATCH_NS);
    fail_count++;
    wrap_up();
  end

endmodule

`default_nettype wire
